/* File: hdl/tfpwm_pkg.sv */
// constants and types for the fast and dual-slope pwm timer
`default_nettype none
package tfpwm_pkg;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 3;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] BOTTOM_VAL = 16'h0000;
    localparam logic [15:0] MAX_VAL = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam int CH_A = 0;
    // waveform mode field encodings
    localparam logic [3:0] WM_PC8 = 4'h1;
    localparam logic [3:0] WM_PC9 = 4'h2;
    localparam logic [3:0] WM_PC10 = 4'h3;
    localparam logic [3:0] WM_FP8 = 4'h5;
    localparam logic [3:0] WM_FP9 = 4'h6;
    localparam logic [3:0] WM_FP10 = 4'h7;
    localparam logic [3:0] WM_PC_CAP = 4'hA;
    localparam logic [3:0] WM_PC_CMPA = 4'hB;
    localparam logic [3:0] WM_FP_CAP = 4'hE;
    localparam logic [3:0] WM_FP_CMPA = 4'hF;
    // output action field encodings
    typedef enum logic [1:0] {
        TFPWM_ACT_OFF = 2'h0,
        TFPWM_ACT_TOGGLE = 2'h1,
        TFPWM_ACT_NONINV = 2'h2,
        TFPWM_ACT_INV = 2'h3
    } tfpwm_action_t;
endpackage : tfpwm_pkg
`default_nettype wire

/* File: hdl/tfpwm_core.sv */
// fast and phase correct pwm waveform generator for a 16-bit timer
// Contract
// RL1 - fast pwm modes 5,6,7,14,15 count zero up to top, then restart
// RL2 - fast top fixed 8/9/10 bit, capture or compare a; clear after top
// RL3 - fast non-inverting clears on match, sets at wrap; inverting opposite
// RL4 - action two gives non-inverted, three inverted pwm per channel
// RL5 - fast overflow flag at top; compare a or capture flag when top source
// RL6 - channel match flag whenever count equals its active compare value
// RL7 - fixed top masks unused upper bits of written compare values
// RL8 - capture top unbuffered; written below count, counter runs through ffff
// RL9 - compare writes buffered; fast pwm loads them at top with clear
// RL10 - fast zero compare spikes each period; compare at top gives constant
// RL11 - fast mode 15 with action one toggles output a on match
// RL12 - phase correct modes 1,2,3,10,11 count up to top and down
// RL13 - phase correct top fixed, capture or compare a; holds top one tick
// RL14 - phase correct clears on up match, sets on down; inverting opposite
// RL15 - phase correct overflow at zero; buffers load at top with top flag
// RL16 - software keeps register top between 0x0003 and 0xFFFF
// RL17 - phase correct compare zero stays low, compare top stays high
// RL18 - phase correct mode 11 with action one toggles output a on match
// RL19 - waveform reaches pin only while its direction bit selects output
// RL20 - software keeps top not below any compare value
// RL21 - software prefers frequency correct mode when changing top live
// RL22 - mode field picks counting; action fields only pick pin behaviour
// RL23 - counter, flags and buffers advance only on timer tick enable
`default_nettype none
module tfpwm_core #(
    parameter int CH = tfpwm_pkg::NUM_CH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic timer_tick,
    input wire logic [3:0] waveform_mode_field,
    input wire logic [2*CH-1:0] output_action_field,
    input wire logic [CH-1:0] pin_direction_bit,
    input wire logic [CH-1:0] compare_wr,
    input wire logic [16*CH-1:0] compare_wdata,
    input wire logic [15:0] capture_top_value,
    output logic [15:0] count_value,
    output logic [16*CH-1:0] compare_value,
    output logic [CH-1:0] waveform_output,
    output logic [CH-1:0] pin_out,
    output logic [CH-1:0] pin_oe_n,
    output logic overflow_flag_set,
    output logic capture_flag_set,
    output logic [CH-1:0] compare_flag_set,
    output logic pwm_mode_active
);
    import tfpwm_pkg::*;

    // decodes the mode field into family and top value
    function automatic logic is_fast(input logic [3:0] m);
        return m == WM_FP8 || m == WM_FP9 || m == WM_FP10 ||
               m == WM_FP_CAP || m == WM_FP_CMPA;
    endfunction : is_fast

    function automatic logic is_pc(input logic [3:0] m);
        return m == WM_PC8 || m == WM_PC9 || m == WM_PC10 ||
               m == WM_PC_CAP || m == WM_PC_CMPA;
    endfunction : is_pc

    // mask that clears bits above a fixed top, all ones otherwise
    function automatic logic [15:0] fixed_mask(input logic [3:0] m);
        case (m)
            WM_PC8, WM_FP8: return TOP_8BIT;
            WM_PC9, WM_FP9: return TOP_9BIT;
            WM_PC10, WM_FP10: return TOP_10BIT;
            default: return MAX_VAL;
        endcase
    endfunction : fixed_mask

    logic [15:0] count_reg;
    logic down_reg;
    logic [15:0] ocr_buf_reg [CH];
    logic [15:0] ocr_reg [CH];
    logic [CH-1:0] wave_reg;
    logic ovf_reg;
    logic cap_reg;
    logic [CH-1:0] cmp_reg;
    logic fast;
    logic pc;
    logic [15:0] top;
    logic at_top;
    logic at_bottom;
    logic [15:0] count_next;
    logic down_next;
    logic load_ocr;
    logic [CH-1:0] hit;
    tfpwm_action_t act [CH];

    assign fast = is_fast(waveform_mode_field); // RL1 RL22
    assign pc = is_pc(waveform_mode_field); // RL12 RL22
    assign pwm_mode_active = fast | pc;

    // top source: fixed, unbuffered capture register or active compare a
    always_comb begin
        case (waveform_mode_field)
            WM_PC_CAP, WM_FP_CAP: top = capture_top_value; // RL8 RL2 RL13
            WM_PC_CMPA, WM_FP_CMPA: top = ocr_reg[CH_A];
            default: top = fixed_mask(waveform_mode_field); // RL2 RL13
        endcase
    end

    assign at_top = count_reg == top;
    assign at_bottom = count_reg == BOTTOM_VAL;
    // fast loads at top (same tick as clear), phase correct at top too
    assign load_ocr = timer_tick & at_top & (fast | pc); // RL9 RL15

    // per-channel match of the count and the channel's action code
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            hit[i] = count_reg == ocr_reg[i]; // RL6
            act[i] = tfpwm_action_t'(output_action_field[2*i +: 2]);
        end
    end

    // next count: fast wraps after top, phase correct reverses at ends
    always_comb begin
        count_next = count_reg;
        down_next = down_reg;
        if (fast) begin
            // missed top just runs on and wraps at 0xFFFF
            if (at_top) begin
                count_next = BOTTOM_VAL; // RL1 RL2 RL8
            end else begin
                count_next = 16'(count_reg + 16'h0001);
            end
            down_next = 1'b0;
        end else if (pc) begin
            if (at_top && at_bottom) begin
                // zero top is degenerate: park at zero until a top loads
                down_next = 1'b0;
                count_next = BOTTOM_VAL;
            end else if (at_top && !down_reg) begin
                // top stands for this one tick only, then count falls
                down_next = 1'b1; // RL13
                count_next = 16'(count_reg - 16'h0001);
            end else if (down_reg) begin
                if (at_bottom) begin
                    down_next = 1'b0;
                    count_next = 16'(count_reg + 16'h0001);
                end else begin
                    count_next = 16'(count_reg - 16'h0001); // RL12
                end
            end else begin
                count_next = 16'(count_reg + 16'h0001); // RL12
            end
        end
    end

    // counter and direction, advanced on timer ticks only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_reg <= COUNT_RESET;
            down_reg <= 1'b0;
        end else if (timer_tick) begin // RL23
            count_reg <= count_next;
            down_reg <= down_next;
        end
    end

    // compare buffers and active compare registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < CH; i++) begin
                ocr_buf_reg[i] <= COMPARE_RESET;
                ocr_reg[i] <= COMPARE_RESET;
            end
        end else begin
            for (int i = 0; i < CH; i++) begin
                if (compare_wr[i]) begin
                    ocr_buf_reg[i] <= compare_wdata[16*i +: 16] &
                        fixed_mask(waveform_mode_field); // RL7 RL9
                end
                if (load_ocr) begin
                    ocr_reg[i] <= ocr_buf_reg[i]; // RL9 RL15
                end
            end
        end
    end

    // one-tick event pulses for overflow, capture-top and compare matches
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovf_reg <= 1'b0;
            cap_reg <= 1'b0;
            cmp_reg <= '0;
        end else begin
            ovf_reg <= timer_tick & ((fast & at_top) |
                (pc & at_bottom & down_reg)); // RL5 RL15
            cap_reg <= timer_tick & at_top & (fast | pc) &
                (waveform_mode_field == WM_PC_CAP ||
                 waveform_mode_field == WM_FP_CAP); // RL5 RL15
            for (int i = 0; i < CH; i++) begin
                cmp_reg[i] <= timer_tick & (fast | pc) &
                    (count_reg == ocr_reg[i]); // RL6 RL5
            end
        end
    end

    // output compare flip-flops; action field picks pin behaviour only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wave_reg <= '0;
        end else if (timer_tick) begin
            for (int i = 0; i < CH; i++) begin
                if (act[i] == TFPWM_ACT_NONINV ||
                    act[i] == TFPWM_ACT_INV) begin
                    if (fast) begin
                        // wrap sets, match clears; match at top wins
                        if (hit[i]) begin
                            wave_reg[i] <= act[i] == TFPWM_ACT_INV; // RL3 RL4
                        end else if (at_top) begin
                            wave_reg[i] <= act[i] == TFPWM_ACT_NONINV; // RL10
                        end
                    end else if (pc) begin
                        if (hit[i] && ocr_reg[i] == BOTTOM_VAL) begin
                            wave_reg[i] <= act[i] == TFPWM_ACT_INV; // RL17
                        end else if (hit[i] && ocr_reg[i] == top) begin
                            wave_reg[i] <= act[i] == TFPWM_ACT_NONINV; // RL17
                        end else if (hit[i]) begin
                            wave_reg[i] <= down_reg ^
                                (act[i] == TFPWM_ACT_INV); // RL14 RL4
                        end
                    end
                end else if (act[i] == TFPWM_ACT_TOGGLE && i == CH_A &&
                    hit[i] &&
                    (waveform_mode_field == WM_FP_CMPA ||
                     waveform_mode_field == WM_PC_CMPA)) begin
                    wave_reg[i] <= ~wave_reg[i]; // RL11 RL18
                end
            end
        end
    end

    // pin drive gated by direction bits
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            pin_out[i] = pin_direction_bit[i] & wave_reg[i]; // RL19
            pin_oe_n[i] = ~pin_direction_bit[i]; // RL19
            compare_value[16*i +: 16] = ocr_reg[i];
        end
    end

    assign count_value = count_reg;
    assign waveform_output = wave_reg;
    assign overflow_flag_set = ovf_reg;
    assign capture_flag_set = cap_reg;
    assign compare_flag_set = cmp_reg;

    // checks on the counting sequence of both families
    a_fast_wrap: assert property (@(posedge sys_clk) disable iff (rst) // RL1
        timer_tick && fast && at_top |=> count_reg == BOTTOM_VAL)
        else $error("fast count did not wrap after top");
    a_fixed_top8: assert property (@(posedge sys_clk) disable iff (rst) // RL2
        waveform_mode_field == WM_FP8 && $stable(waveform_mode_field)
        |-> count_reg <= TOP_8BIT || $past(count_reg) > TOP_8BIT)
        else $error("fast 8-bit count above top");
    a_pc_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL13
        timer_tick && pc && at_top && !down_reg && top != BOTTOM_VAL
        |=> down_reg && count_reg == 16'($past(count_reg) - 16'h0001))
        else $error("phase correct top stood more than one tick");
    a_pc_fall: assert property (@(posedge sys_clk) disable iff (rst) // RL12
        timer_tick && pc && down_reg && !at_bottom
        |=> count_reg == 16'($past(count_reg) - 16'h0001))
        else $error("phase correct did not count down");
    a_pc_rise: assert property (@(posedge sys_clk) disable iff (rst) // RL12
        timer_tick && pc && down_reg && at_bottom
        |=> !down_reg && count_reg == 16'h0001)
        else $error("phase correct did not turn at bottom");
    a_idle_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL22
        timer_tick && !pwm_mode_active |=> $stable(count_reg))
        else $error("counter moved in a non-pwm mode");

    // checks on the event pulses
    a_ovf_fast: assert property (@(posedge sys_clk) disable iff (rst) // RL5
        timer_tick && fast && at_top |=> overflow_flag_set)
        else $error("overflow not set at fast top");
    a_ovf_pc: assert property (@(posedge sys_clk) disable iff (rst) // RL15
        overflow_flag_set |-> $past(pc && at_bottom && down_reg) ||
        $past(fast && at_top))
        else $error("overflow set at wrong point");
    a_cap_fast: assert property (@(posedge sys_clk) disable iff (rst) // RL5
        timer_tick && at_top && waveform_mode_field == WM_FP_CAP
        |=> capture_flag_set)
        else $error("capture flag missing at fast top");
    a_cap_pc: assert property (@(posedge sys_clk) disable iff (rst) // RL15
        timer_tick && at_top && waveform_mode_field == WM_PC_CAP
        |=> capture_flag_set)
        else $error("capture flag missing at phase correct top");
    a_cmp_flag: assert property (@(posedge sys_clk) disable iff (rst) // RL6
        timer_tick && fast && count_reg == ocr_reg[CH_A]
        |=> compare_flag_set[CH_A])
        else $error("compare a flag missing on match");

    // checks on compare buffering and masking
    a_ocr_load: assert property (@(posedge sys_clk) disable iff (rst) // RL9
        load_ocr && !compare_wr[CH_A]
        |=> ocr_reg[CH_A] == $past(ocr_buf_reg[CH_A]))
        else $error("compare a not loaded at top");
    a_ocr_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL9
        !load_ocr |=> $stable(ocr_reg[CH_A]))
        else $error("compare a changed outside top");
    a_mask_wr: assert property (@(posedge sys_clk) disable iff (rst) // RL7
        compare_wr[1] && fixed_mask(waveform_mode_field) == TOP_8BIT
        |=> ocr_buf_reg[1][15:8] == 8'h00)
        else $error("upper compare bits not masked");

    // checks on the waveform and the pins
    a_fast_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL3
        timer_tick && fast && count_reg == ocr_reg[CH_A] &&
        output_action_field[1:0] == TFPWM_ACT_NONINV
        |=> !waveform_output[CH_A])
        else $error("fast non-inverting output not cleared");
    a_fast_set: assert property (@(posedge sys_clk) disable iff (rst) // RL3
        timer_tick && fast && at_top && !hit[CH_A] &&
        act[CH_A] == TFPWM_ACT_NONINV |=> waveform_output[CH_A])
        else $error("fast non-inverting output not set at wrap");
    a_toggle_a: assert property (@(posedge sys_clk) disable iff (rst) // RL11
        timer_tick && hit[CH_A] && act[CH_A] == TFPWM_ACT_TOGGLE &&
        waveform_mode_field == WM_FP_CMPA
        |=> waveform_output[CH_A] != $past(waveform_output[CH_A]))
        else $error("output a did not toggle on match");
    a_pin_gate: assert property (@(posedge sys_clk) disable iff (rst) // RL19
        !pin_direction_bit[CH_A] |-> !pin_out[CH_A] && pin_oe_n[CH_A])
        else $error("pin shows waveform while input");
    a_pin_drive: assert property (@(posedge sys_clk) disable iff (rst) // RL19
        pin_direction_bit[CH_A]
        |-> pin_out[CH_A] == waveform_output[CH_A] && !pin_oe_n[CH_A])
        else $error("pin does not follow waveform while output");
    a_no_tick: assert property (@(posedge sys_clk) disable iff (rst) // RL23
        !timer_tick |=> $stable(count_reg) && !overflow_flag_set)
        else $error("counter moved without tick");

    // main scenarios worth seeing
    c_fast_period: cover property (@(posedge sys_clk)
        fast && overflow_flag_set);
    c_pc_turn: cover property (@(posedge sys_clk)
        pc && $rose(down_reg));
    c_pc_bottom: cover property (@(posedge sys_clk)
        pc && overflow_flag_set);
    c_toggle_a: cover property (@(posedge sys_clk)
        output_action_field[1:0] == TFPWM_ACT_TOGGLE &&
        $changed(waveform_output[CH_A]));
    c_cap_top: cover property (@(posedge sys_clk) capture_flag_set);
endmodule : tfpwm_core
`default_nettype wire

/* File: verif/tfpwm_load_model.sv */
// load model for the waveform pins: power stage inputs with pull-downs
`default_nettype none
module tfpwm_load_model #(
    parameter int CH = tfpwm_pkg::NUM_CH
) (
    input wire logic [CH-1:0] pin_out,
    input wire logic [CH-1:0] pin_oe_n,
    output logic [CH-1:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // a released pin is pulled low by the stage input resistor
    assign pin_level = pin_out & ~pin_oe_n;
endmodule : tfpwm_load_model
`default_nettype wire

/* File: verif/timer_fast_and_dual_slope_pwm_tb.sv */
// self-checking bench for the fast and dual-slope pwm timer
`default_nettype none
module timer_fast_and_dual_slope_pwm_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tfpwm_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic timer_tick = 1'b1;
    logic [3:0] waveform_mode_field = MODE_RESET;
    logic [5:0] output_action_field = 6'h00;
    logic [2:0] pin_direction_bit = 3'h0;
    logic [2:0] compare_wr = 3'h0;
    logic [47:0] compare_wdata = 48'h0;
    logic [15:0] capture_top_value = 16'h0000;
    logic [15:0] count_value;
    logic [15:0] held;
    logic [47:0] compare_value;
    logic [2:0] waveform_output, pin_out, pin_oe_n, compare_flag_set;
    logic [2:0] pin_level;
    logic overflow_flag_set, capture_flag_set, pwm_mode_active;
    logic found, w_prev;
    int err_count = 0;
    int compares = 0;
    // 20 MHz system clock
    always #25 sys_clk = ~sys_clk;
    tfpwm_core tfpwm_core_i (.sys_clk(sys_clk), .rst(rst),
        .timer_tick(timer_tick), .waveform_mode_field(waveform_mode_field),
        .output_action_field(output_action_field),
        .pin_direction_bit(pin_direction_bit), .compare_wr(compare_wr),
        .compare_wdata(compare_wdata), .capture_top_value(capture_top_value),
        .count_value(count_value), .compare_value(compare_value),
        .waveform_output(waveform_output), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .overflow_flag_set(overflow_flag_set),
        .capture_flag_set(capture_flag_set),
        .compare_flag_set(compare_flag_set),
        .pwm_mode_active(pwm_mode_active));
    tfpwm_load_model tfpwm_load_model_i (.pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_level(pin_level));
    // inputs change 1 ns after the rising edge
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // bounded wait until the counter shows a value
    task automatic wait_cnt(input logic [15:0] v);
        found = 1'b0;
        for (int i = 0; i < 70000 && !found; i++) begin
            if (count_value === v) found = 1'b1;
            else step();
        end
        chk("count reached", 16'h0001, {15'h0, found});
    endtask : wait_cnt
    task automatic wr(input logic [2:0] m, input logic [47:0] d);
        compare_wr = m;
        compare_wdata = d;
        step();
        compare_wr = 3'h0;
    endtask : wr
    task automatic do_reset;
        rst = 1'b1;
        repeat (20) step();
        rst = 1'b0;
    endtask : do_reset
    task automatic stop_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // fast 8-bit: buffering, masking, both polarities, pins, tick gating
    task automatic t_fast8;
        do_reset();
        waveform_mode_field = WM_FP8;
        output_action_field = {2'h0, TFPWM_ACT_INV, TFPWM_ACT_NONINV};
        pin_direction_bit = 3'b001;
        wr(3'b011, {16'h0, 16'h1234, 16'h0010});
        chk("active", 16'h1, pwm_mode_active);
        chk("cmp0 early", 16'h0, compare_value[15:0]);
        wait_cnt(TOP_8BIT);
        step();
        chk("wrap count", 16'h0, count_value);
        chk("ovf at top", 16'h1, overflow_flag_set);
        chk("cmp0 load", 16'h0010, compare_value[15:0]);
        chk("cmp1 mask", 16'h0034, compare_value[31:16]);
        chk("out0 wrap", 16'h1, waveform_output[0]);
        chk("out1 wrap", 16'h0, waveform_output[1]);
        chk("pin0", 16'h1, pin_level[0]);
        wait_cnt(16'h0010);
        step();
        chk("out0 match", 16'h0, waveform_output[0]);
        chk("flag0", 16'h1, compare_flag_set[0]);
        chk("ovf quiet", 16'h0, overflow_flag_set);
        wait_cnt(16'h0034);
        step();
        chk("out1 match", 16'h1, waveform_output[1]);
        chk("flag1", 16'h1, compare_flag_set[1]);
        chk("pin1 off", 16'h0, pin_out[1]);
        chk("oe1", 16'h1, pin_oe_n[1]);
        chk("oe0", 16'h0, pin_oe_n[0]);
        held = count_value;
        timer_tick = 1'b0;
        repeat (4) step();
        chk("no tick", held, count_value);
        timer_tick = 1'b1;
    endtask : t_fast8
    // fast with compare a as top at the minimum, toggling output a
    task automatic t_fast_toggle;
        do_reset();
        waveform_mode_field = WM_FP_CMPA;
        output_action_field = {4'h0, TFPWM_ACT_TOGGLE};
        wr(3'b001, {32'h0, 16'h0003});
        wait_cnt(16'h0003);
        step();
        chk("wrap count", 16'h0, count_value);
        chk("ovf", 16'h1, overflow_flag_set);
        chk("top flag", 16'h1, compare_flag_set[0]);
        w_prev = waveform_output[0];
        wait_cnt(16'h0003);
        step();
        chk("toggle", {15'h0, ~w_prev}, waveform_output[0]);
    endtask : t_fast_toggle
    // capture top lowered below the count: counter runs through max
    task automatic t_cap_miss;
        do_reset();
        waveform_mode_field = WM_FP_CAP;
        capture_top_value = 16'h0020;
        wait_cnt(16'h0020);
        step();
        chk("cap flag", 16'h1, capture_flag_set);
        chk("wrap count", 16'h0, count_value);
        wait_cnt(16'h0018);
        capture_top_value = 16'h0010;
        wait_cnt(MAX_VAL);
        step();
        chk("max wrap", 16'h0, count_value);
        wait_cnt(16'h0010);
        step();
        chk("new top", 16'h0, count_value);
        chk("cap flag2", 16'h1, capture_flag_set);
    endtask : t_cap_miss
    // phase correct with a static capture top, then a non-pwm mode
    task automatic t_phase;
        do_reset();
        waveform_mode_field = WM_PC_CAP;
        capture_top_value = 16'h0010;
        output_action_field = {2'h0, TFPWM_ACT_INV, TFPWM_ACT_NONINV};
        wr(3'b011, {16'h0, 16'h0010, 16'h0008});
        wait_cnt(16'h0010);
        step();
        chk("turn", 16'h000F, count_value);
        chk("cap flag", 16'h1, capture_flag_set);
        chk("cmp0 load", 16'h0008, compare_value[15:0]);
        wait_cnt(16'h0008);
        step();
        chk("down set", 16'h1, waveform_output[0]);
        chk("flag0", 16'h1, compare_flag_set[0]);
        wait_cnt(16'h0000);
        step();
        chk("ovf bottom", 16'h1, overflow_flag_set);
        chk("rise", 16'h0001, count_value);
        wait_cnt(16'h0008);
        step();
        chk("up clear", 16'h0, waveform_output[0]);
        wait_cnt(16'h0010);
        step();
        chk("inv top", 16'h0, waveform_output[1]);
        wait_cnt(16'h0000);
        step();
        chk("inv hold", 16'h0, waveform_output[1]);
        waveform_mode_field = MODE_RESET;
        step();
        held = count_value;
        chk("inactive", 16'h0, pwm_mode_active);
        repeat (3) step();
        chk("hold", held, count_value);
    endtask : t_phase
    // main sequence
    initial begin
        t_fast8();
        t_fast_toggle();
        t_cap_miss();
        t_phase();
        stop_test();
    end
    // watchdog well above the expected run length
    initial begin
        #(80000 * 50);
        err_count++;
        stop_test();
    end
endmodule : timer_fast_and_dual_slope_pwm_tb
`default_nettype wire
